// ==== rtl/iap_dev_end.sv ====
`timescale 1ns/10ps
`include "iap_params.svh"

module upd_dev_end
  import upd_pkg::*;
#(
  parameter logic [15:0] KEY1 = `KEY1_WORD,
  parameter logic [15:0] KEY2 = `KEY2_WORD,
  parameter logic [15:0] KEY3 = `KEY3_WORD
)
(
  input  wire logic               clock,
  input  wire logic               rst_n,
  upd_link_if.dev                 link,
  output      logic               fl_req,
  output      upd_pkg::flash_op_t fl_op,
  output      logic [12:0]        fl_addr,
  output      logic [15:0]        fl_wdata,
  input  wire logic               fl_ack,
  input  wire logic [15:0]        fl_rdata
);
  import upd_pkg::*;

  dev_regs_t r_ff;
  dev_regs_t nxt_r;

  logic       idle;
  logic [2:0] kidx;
  logic [2:0] new_mode;
  logic       keys_ok;
  logic       key_hit;

  assign idle    = (r_ff.st == DEV_IDLE);
  assign keys_ok = ({r_ff.key[1], r_ff.key[0]} == KEY1) &&
                   ({r_ff.key[3], r_ff.key[2]} == KEY2) &&
                   ({r_ff.key[5], r_ff.key[4]} == KEY3);
  assign key_hit = (link.addr >= `REG_KEY1_LO) && (link.addr <= `REG_KEY3_HI);

  always_comb
  begin
    nxt_r    = r_ff;
    kidx     = 3'(link.addr - `REG_KEY1_LO);
    new_mode = link.wdata[`CTRL0_MODE_HI:`CTRL0_MODE_LO];

    // one-cycle clear; a load in the same cycle lands after it
    if (r_ff.clr)
    begin
      nxt_r.wbuf = {`PAGE_WORDS{`BUF_CLEAR_WORD}};
      nxt_r.clr  = 1'b0;
    end

    // unlock procedure timer
    if (r_ff.trig)
    begin
      if (r_ff.tmr <= 16'h0001)
      begin
        nxt_r.trig = 1'b0;
        nxt_r.tmr  = 16'h0000;
      end
      else
      begin
        nxt_r.tmr = r_ff.tmr - 16'h0001;
      end
    end

    if (link.wr)
    begin
      case (link.addr)
        `REG_CTRL0:
        begin
          // software may only drop the flag
          if (!link.wdata[`CTRL0_FLAG_BIT])
          begin
            nxt_r.flag = 1'b0;
          end
          nxt_r.mode = new_mode;
          nxt_r.rden = link.wdata[`CTRL0_RDEN_BIT];
          if (link.wdata[`CTRL0_TRIG_BIT] && !r_ff.trig && new_mode == `MODE_UNLOCK)
          begin
            nxt_r.trig = 1'b1;
            nxt_r.tmr  = 16'(`UNLOCK_CYCLES);
            nxt_r.key  = '0;
          end
          // erase and program need the flag; otherwise the start bit never rises
          if (link.wdata[`CTRL0_PSTART_BIT] && idle && r_ff.flag)
          begin
            if (new_mode == `MODE_PROGRAM)
            begin
              nxt_r.pstart = 1'b1;
              nxt_r.st     = DEV_PROG;
              nxt_r.widx   = 5'h00;
              nxt_r.freq   = 1'b1;
              nxt_r.fop    = FL_PROG;
              nxt_r.faddr  = {r_ff.addr[12:5], 5'h00};
              nxt_r.fwdata = r_ff.wbuf[0];
            end
            else if (new_mode == `MODE_ERASE)
            begin
              nxt_r.pstart = 1'b1;
              nxt_r.st     = DEV_ERASE;
              nxt_r.freq   = 1'b1;
              nxt_r.fop    = FL_ERASE;
              nxt_r.faddr  = {r_ff.addr[12:5], 5'h00};
            end
          end
          // read enable must already be set from an earlier write
          if (link.wdata[`CTRL0_RSTART_BIT] && idle && r_ff.rden &&
              new_mode == `MODE_READ)
          begin
            nxt_r.rstart = 1'b1;
            nxt_r.st     = DEV_READ;
            nxt_r.freq   = 1'b1;
            nxt_r.fop    = FL_READ;
            nxt_r.faddr  = r_ff.addr;
          end
        end
        `REG_CTRL1:   nxt_r.ctl1       = link.wdata;
        `REG_CTRL2:
        begin
          if (link.wdata[`CTRL2_CLEAR_BIT])
          begin
            nxt_r.clr = 1'b1;
          end
        end
        `REG_ADDR_LO: nxt_r.addr[7:0]  = link.wdata;
        `REG_ADDR_HI: nxt_r.addr[12:8] = link.wdata[4:0];
        `REG_DATA_LO: nxt_r.dlo        = link.wdata;
        `REG_DATA_HI:
        begin
          nxt_r.dhi = link.wdata;
          // with the flag low the byte is kept but nothing moves
          if (r_ff.flag)
          begin
            nxt_r.wbuf[r_ff.addr[4:0]] = {link.wdata, r_ff.dlo};
            if (r_ff.addr[4:0] != `LAST_OFFSET)
            begin
              nxt_r.addr = r_ff.addr + 13'h0001;
            end
          end
        end
        default:
        begin
          if (link.addr >= `REG_KEY1_LO && link.addr <= `REG_KEY3_HI)
          begin
            nxt_r.key[kidx] = link.wdata;
          end
        end
      endcase
    end

    // hardware set of the flag wins over a software clear in the same cycle
    if (r_ff.trig && r_ff.mode == `MODE_UNLOCK && keys_ok)
    begin
      nxt_r.flag = 1'b1;
    end

    case (r_ff.st)
      DEV_IDLE:
      begin
      end
      DEV_PROG:
      begin
        if (fl_ack)
        begin
          if (r_ff.widx == `LAST_OFFSET)
          begin
            nxt_r.freq   = 1'b0;
            nxt_r.pstart = 1'b0;
            nxt_r.wbuf   = {`PAGE_WORDS{`BUF_CLEAR_WORD}};
            nxt_r.st     = DEV_IDLE;
          end
          else
          begin
            nxt_r.widx   = r_ff.widx + 5'h01;
            nxt_r.faddr  = {r_ff.faddr[12:5], r_ff.widx + 5'h01};
            nxt_r.fwdata = r_ff.wbuf[r_ff.widx + 5'h01];
          end
        end
      end
      DEV_ERASE:
      begin
        if (fl_ack)
        begin
          nxt_r.freq   = 1'b0;
          nxt_r.pstart = 1'b0;
          nxt_r.st     = DEV_IDLE;
        end
      end
      DEV_READ:
      begin
        if (fl_ack)
        begin
          nxt_r.freq   = 1'b0;
          nxt_r.rstart = 1'b0;
          nxt_r.dlo    = fl_rdata[7:0];
          nxt_r.dhi    = fl_rdata[15:8];
          nxt_r.st     = DEV_IDLE;
        end
      end
      default:
      begin
        nxt_r.st = DEV_IDLE;
      end
    endcase

    // read answer is registered; it shows the state before this cycle's write
    if (link.rd)
    begin
      case (link.addr)
        `REG_CTRL0:   nxt_r.rdata = {r_ff.flag, r_ff.mode, r_ff.trig, r_ff.pstart,
                                     r_ff.rden, r_ff.rstart};
        `REG_CTRL1:   nxt_r.rdata = r_ff.ctl1;
        `REG_CTRL2:   nxt_r.rdata = {7'h00, r_ff.clr};
        `REG_ADDR_LO: nxt_r.rdata = r_ff.addr[7:0];
        `REG_ADDR_HI: nxt_r.rdata = {3'h0, r_ff.addr[12:8]};
        `REG_DATA_LO: nxt_r.rdata = r_ff.dlo;
        `REG_DATA_HI: nxt_r.rdata = r_ff.dhi;
        default:      nxt_r.rdata = key_hit ? r_ff.key[kidx] : 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_ff <= '0;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign link.stall = !idle;
  assign link.rdata = r_ff.rdata;
  assign fl_req     = r_ff.freq;
  assign fl_op      = r_ff.fop;
  assign fl_addr    = r_ff.faddr;
  assign fl_wdata   = r_ff.fwdata;
endmodule

// ==== rtl/iap_fw_end.sv ====
`timescale 1ns/10ps
`include "iap_params.svh"

module upd_fw_end
  import upd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  upd_link_if.fw           link,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [3:0]  cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  output      logic        cmd_ready,
  output      logic        cmd_refused,
  output      logic        rsp_valid,
  output      logic [7:0]  rsp_data
);
  import upd_pkg::*;

  host_regs_t r_ff;
  host_regs_t nxt_r;

  logic       take;
  logic       bad;
  logic [2:0] wmode;

  // one access in flight; the stall holds off the next one
  assign cmd_ready = !r_ff.bus_wr && !r_ff.bus_rd && !r_ff.rd_wait && !link.stall;
  assign take      = cmd_valid && cmd_ready;
  assign wmode     = cmd_wdata[`CTRL0_MODE_HI:`CTRL0_MODE_LO];

  always_comb
  begin
    nxt_r         = r_ff;
    nxt_r.bus_wr  = 1'b0;
    nxt_r.bus_rd  = 1'b0;
    nxt_r.rsp_v   = 1'b0;
    nxt_r.refused = 1'b0;
    nxt_r.rd_wait = r_ff.bus_rd;
    bad           = 1'b0;

    if (r_ff.rd_wait)
    begin
      nxt_r.rsp_v = 1'b1;
      nxt_r.rsp_d = link.rdata;
    end

    if (take && cmd_write)
    begin
      if (cmd_addr == `REG_CTRL0)
      begin
        if (cmd_wdata[`CTRL0_PSTART_BIT] && wmode == `MODE_PROGRAM &&
            !(r_ff.erased_v && r_ff.erased_pg == r_ff.page))
        begin
          bad = 1'b1;
        end
        if (cmd_wdata[`CTRL0_RSTART_BIT] && !r_ff.rden_sh)
        begin
          bad = 1'b1;
        end
      end
      if (cmd_addr == `REG_DATA_HI && !r_ff.buf_ok)
      begin
        bad = 1'b1;
      end
    end

    if (take && bad)
    begin
      nxt_r.refused = 1'b1;
    end
    else if (take)
    begin
      nxt_r.bus_wr = cmd_write;
      nxt_r.bus_rd = !cmd_write;
      nxt_r.baddr  = cmd_addr;
      nxt_r.bwdata = cmd_wdata;
      if (cmd_write)
      begin
        case (cmd_addr)
          `REG_CTRL0:
          begin
            nxt_r.rden_sh = cmd_wdata[`CTRL0_RDEN_BIT];
            if (cmd_wdata[`CTRL0_PSTART_BIT] && wmode == `MODE_ERASE)
            begin
              nxt_r.erased_v  = 1'b1;
              nxt_r.erased_pg = r_ff.page;
            end
            if (cmd_wdata[`CTRL0_PSTART_BIT] && wmode == `MODE_PROGRAM)
            begin
              nxt_r.erased_v = 1'b0;
            end
            // a verify read may find bad data: reload only after a fresh clear
            if (cmd_wdata[`CTRL0_RSTART_BIT])
            begin
              nxt_r.buf_ok = 1'b0;
            end
          end
          `REG_CTRL2:
          begin
            if (cmd_wdata[`CTRL2_CLEAR_BIT])
            begin
              nxt_r.buf_ok = 1'b1;
            end
          end
          `REG_ADDR_LO:
          begin
            nxt_r.page[2:0] = cmd_wdata[7:5];
          end
          `REG_ADDR_HI:
          begin
            nxt_r.page[7:3] = cmd_wdata[4:0];
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_ff <= '0;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign link.wr     = r_ff.bus_wr;
  assign link.rd     = r_ff.bus_rd;
  assign link.addr   = r_ff.baddr;
  assign link.wdata  = r_ff.bwdata;
  assign cmd_refused = r_ff.refused;
  assign rsp_valid   = r_ff.rsp_v;
  assign rsp_data    = r_ff.rsp_d;
endmodule

// ==== rtl/iap_link_if.sv ====
`timescale 1ns/10ps
interface upd_link_if;
  logic        wr;
  logic        rd;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        stall;

  modport dev (
    input  wr,
    input  rd,
    input  addr,
    input  wdata,
    output rdata,
    output stall
  );

  modport fw (
    output wr,
    output rd,
    output addr,
    output wdata,
    input  rdata,
    input  stall
  );
endinterface

// ==== rtl/iap_params.svh ====
`ifndef UPD_PARAMS_SVH
`define UPD_PARAMS_SVH

// register indices seen by the cpu
`define REG_CTRL0         4'h0
`define REG_CTRL1         4'h1
`define REG_CTRL2         4'h2
`define REG_ADDR_LO       4'h3
`define REG_ADDR_HI       4'h4
`define REG_DATA_LO       4'h5
`define REG_DATA_HI       4'h6
`define REG_KEY1_LO       4'h7
`define REG_KEY3_HI       4'hC

// control register zero and two field positions
`define CTRL0_FLAG_BIT    7
`define CTRL0_MODE_HI     6
`define CTRL0_MODE_LO     4
`define CTRL0_TRIG_BIT    3
`define CTRL0_PSTART_BIT  2
`define CTRL0_RDEN_BIT    1
`define CTRL0_RSTART_BIT  0
`define CTRL2_CLEAR_BIT   0

// operation select codes
`define MODE_PROGRAM      3'h0
`define MODE_ERASE        3'h1
`define MODE_READ         3'h3
`define MODE_UNLOCK       3'h6

// page geometry
`define PAGE_WORDS        32
`define LAST_OFFSET       5'h1F
`define BUF_CLEAR_WORD    16'h0000

// unlock procedure window
`define CLOCK_PERIOD_NS   100
`define UNLOCK_WINDOW_NS  50000
`define UNLOCK_CYCLES     (`UNLOCK_WINDOW_NS / `CLOCK_PERIOD_NS)

// unlock key words, arbitrary values
`define KEY1_WORD         16'hA5C3
`define KEY2_WORD         16'h3C5A
`define KEY3_WORD         16'h0FF0

`endif

// ==== rtl/iap_pkg.sv ====
package upd_pkg;

  typedef enum logic [1:0] {DEV_IDLE, DEV_ERASE, DEV_PROG, DEV_READ} dev_state_t;

  typedef enum logic [1:0] {FL_ERASE, FL_PROG, FL_READ} flash_op_t;

  typedef struct packed {
    dev_state_t         st;
    logic               flag;
    logic [2:0]         mode;
    logic               trig;
    logic               pstart;
    logic               rden;
    logic               rstart;
    logic [7:0]         ctl1;
    logic               clr;
    logic [12:0]        addr;
    logic [7:0]         dlo;
    logic [7:0]         dhi;
    logic [5:0][7:0]    key;
    logic [15:0]        tmr;
    logic [4:0]         widx;
    logic               freq;
    flash_op_t          fop;
    logic [12:0]        faddr;
    logic [15:0]        fwdata;
    logic [7:0]         rdata;
    logic [31:0][15:0]  wbuf;
  } dev_regs_t;

  typedef struct packed {
    logic               bus_wr;
    logic               bus_rd;
    logic [3:0]         baddr;
    logic [7:0]         bwdata;
    logic               rd_wait;
    logic               rsp_v;
    logic [7:0]         rsp_d;
    logic               refused;
    logic [7:0]         page;
    logic               erased_v;
    logic [7:0]         erased_pg;
    logic               rden_sh;
    logic               buf_ok;
  } host_regs_t;

endpackage

// ==== verif/flash_self_update_write_buffer_tb.sv ====
`timescale 1ns/10ps
`include "iap_params.svh"

module flash_self_update_write_buffer_tb;
  import upd_pkg::*;
  logic        clock;
  logic        rst_n;
  logic        cmd_valid;
  logic        cmd_write;
  logic [3:0]  cmd_addr;
  logic [7:0]  cmd_wdata;
  logic        cmd_ready;
  logic        cmd_refused;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic        fl_req;
  flash_op_t   fl_op;
  logic [12:0] fl_addr;
  logic [15:0] fl_wdata;
  logic        fl_ack;
  logic [15:0] fl_rdata;
  logic [1:0]  ack_cnt;
  int          mismatches;
  int          compares;
  flash_op_t   op_q[$];
  logic [12:0] addr_q[$];
  logic [15:0] data_q[$];
  logic [15:0] pw;
  logic [47:0] keys;

  upd_link_if upd_link_if_i ();
  upd_dev_end upd_dev_end_i (.clock(clock), .rst_n(rst_n), .link(upd_link_if_i),
    .fl_req(fl_req), .fl_op(fl_op), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .fl_ack(fl_ack), .fl_rdata(fl_rdata));
  upd_fw_end upd_fw_end_i (.clock(clock), .rst_n(rst_n), .link(upd_link_if_i),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .cmd_refused(cmd_refused),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  upd_link_monitor upd_link_monitor_i (.clock(clock), .rst_n(rst_n),
    .wr(upd_link_if_i.wr), .rd(upd_link_if_i.rd), .addr(upd_link_if_i.addr),
    .rdata(upd_link_if_i.rdata), .stall(upd_link_if_i.stall), .fl_req(fl_req),
    .fl_op(fl_op), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  function automatic logic [15:0] pattern(input logic [12:0] a);
    return {3'h0, a} ^ 16'h5A00;
  endfunction

  // array acks on the third cycle of a request, on the fourth for each later program word; read data is inverted
  // outside the ack so a stale word can never pass for a fresh one
  wire ack_go = fl_req === 1'b1 && fl_ack !== 1'b1 && ack_cnt == 2'h2;
  always @(negedge clock)
  begin
    fl_ack   <= ack_go;
    ack_cnt  <= (fl_req === 1'b1 && !ack_go && fl_ack !== 1'b1) ? ack_cnt + 2'h1 : 2'h0;
    fl_rdata <= ack_go ? pattern(fl_addr) : ~pattern(fl_addr);
    if (ack_go)
    begin
      op_q.push_back(fl_op);
      addr_q.push_back(fl_addr);
      data_q.push_back(fl_wdata);
    end
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stuck(input string what);
    mismatches++;
    $display("[FAIL] %s expected response seen none", what);
    print_verdict();
  endtask

  // command is held from a falling edge until the falling edge after the rising edge that takes it
  task automatic cmd(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr  = a;
    cmd_wdata = d;
    n = 0;
    #1;
    while (cmd_ready !== 1'b1 && n < 3000)
    begin
      @(negedge clock);
      #1;
      n++;
    end
    if (n == 3000)
      stuck("cmd_ready");
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cmd(1'b1, a, d);
  endtask

  // the refusal pulse stands from the taking edge to the next one
  task automatic wr_ref(input logic [3:0] a, input logic [7:0] d, input logic exp,
                        input string what);
    cmd(1'b1, a, d);
    check(what, {15'h0, exp}, {15'h0, cmd_refused});
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    int n;
    cmd(1'b0, a, 8'h00);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 20)
      stuck(what);
    check(what, {8'h00, exp}, {8'h00, rsp_data});
  endtask

  task automatic clear_log();
    op_q.delete();
    addr_q.delete();
    data_q.delete();
  endtask

  task automatic done(input string what);
    $display("test %s finished", what);
  endtask

  initial
  begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 4'h0;
    cmd_wdata = 8'h00;
    fl_ack = 1'b0;
    ack_cnt = 2'h0;
    fl_rdata = 16'h0000;
    mismatches = 0;
    compares = 0;
    keys = {`KEY3_WORD, `KEY2_WORD, `KEY1_WORD};
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    rd_chk(`REG_CTRL0, 8'h00, "ctrl0 reset");
    rd_chk(`REG_CTRL2, 8'h00, "ctrl2 reset");
    rd_chk(`REG_ADDR_HI, 8'h00, "addr_hi reset");
    wr(`REG_CTRL1, 8'h3C);
    rd_chk(`REG_CTRL1, 8'h3C, "ctrl1 store");
    done("reset");
    wr(`REG_CTRL2, 8'h01);
    rd_chk(`REG_CTRL2, 8'h00, "buffer clear bit");
    wr(`REG_ADDR_LO, 8'h25);
    wr(`REG_DATA_LO, 8'h11);
    wr(`REG_DATA_HI, 8'h22);
    rd_chk(`REG_ADDR_LO, 8'h25, "address with flag low");
    done("locked load");
    wr(`REG_CTRL0, 8'h68);
    rd_chk(`REG_CTRL0, 8'h68, "trigger set");
    for (int i = 0; i < 6; i++)
      wr(4'(`REG_KEY1_LO + i), keys[i*8 +: 8]);
    rd_chk(`REG_CTRL0, 8'hE8, "unlocked");
    repeat (500) @(negedge clock);
    rd_chk(`REG_CTRL0, 8'hE0, "trigger timeout");
    done("unlock");
    wr(`REG_ADDR_HI, 8'h1F);
    wr(`REG_ADDR_LO, 8'hE7);
    clear_log();
    wr(`REG_CTRL0, 8'h94);
    rd_chk(`REG_CTRL0, 8'h90, "erase done");
    check("erase count", 16'h0001, 16'(op_q.size()));
    check("erase op", 16'(FL_ERASE), 16'(op_q[0]));
    check("erase page", 16'h1FE0, {3'h0, addr_q[0]});
    done("erase");
    wr(`REG_ADDR_LO, 8'hFD);
    for (int i = 0; i < 4; i++)
    begin
      wr(`REG_DATA_LO, 8'h10 + 8'(i));
      wr(`REG_DATA_HI, 8'hA0 + 8'(i));
      rd_chk(`REG_ADDR_LO, (i < 2) ? 8'hFE + 8'(i) : 8'hFF, "address step");
    end
    rd_chk(`REG_ADDR_HI, 8'h1F, "address page");
    clear_log();
    wr(`REG_CTRL0, 8'h84);
    rd_chk(`REG_CTRL0, 8'h80, "program done");
    check("program count", 16'h0020, 16'(op_q.size()));
    for (int j = 0; j < 32; j++)
    begin
      pw = (j == 29) ? 16'hA010 : (j == 30) ? 16'hA111 : (j == 31) ? 16'hA313 : 16'h0000;
      check("program addr", 16'h1FE0 + 16'(j), {3'h0, addr_q[j]});
      check("program data", pw, data_q[j]);
    end
    done("page program");
    clear_log();
    wr(`REG_CTRL0, 8'h94);
    wr(`REG_CTRL0, 8'h84);
    rd_chk(`REG_CTRL0, 8'h80, "reprogram done");
    check("reprogram count", 16'h0021, 16'(op_q.size()));
    for (int j = 1; j < 33; j++)
      check("cleared buffer", 16'h0000, data_q[j]);
    done("auto clear");
    wr(`REG_ADDR_HI, 8'h1F);
    wr(`REG_ADDR_LO, 8'h42);
    clear_log();
    wr(`REG_CTRL0, 8'hB2);
    wr(`REG_CTRL0, 8'hB3);
    rd_chk(`REG_CTRL0, 8'hB2, "read start cleared");
    pw = pattern(13'h1F42);
    check("read op", 16'(FL_READ), 16'(op_q[0]));
    check("read addr", 16'h1F42, {3'h0, addr_q[0]});
    rd_chk(`REG_DATA_LO, pw[7:0], "read low");
    rd_chk(`REG_DATA_HI, pw[15:8], "read high");
    done("read");
    wr_ref(`REG_DATA_HI, 8'h55, 1'b1, "load after verify read");
    wr(`REG_CTRL2, 8'h01);
    wr_ref(`REG_DATA_HI, 8'h55, 1'b0, "load after clear");
    rd_chk(`REG_ADDR_LO, 8'h43, "address after load");
    wr(`REG_CTRL2, 8'h01);
    clear_log();
    wr(`REG_CTRL0, 8'h94);
    wr_ref(`REG_CTRL0, 8'h84, 1'b0, "program after erase");
    rd_chk(`REG_CTRL0, 8'h80, "clear program done");
    check("clear program count", 16'h0021, 16'(op_q.size()));
    check("clear program page", 16'h1F40, {3'h0, addr_q[1]});
    for (int j = 1; j < 33; j++)
      check("manually cleared buffer", 16'h0000, data_q[j]);
    wr_ref(`REG_CTRL0, 8'h84, 1'b1, "program without erase");
    wr_ref(`REG_CTRL0, 8'hB1, 1'b1, "read start without enable");
    rd_chk(`REG_CTRL0, 8'h80, "refused starts");
    done("refusals");
    print_verdict();
  end
endmodule

// ==== verif/iap_link_monitor.sv ====
`timescale 1ns/10ps
module upd_link_monitor
  import upd_pkg::*;
(
  input wire logic               clock,
  input wire logic               rst_n,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [3:0]         addr,
  input wire logic [7:0]         rdata,
  input wire logic               stall,
  input wire logic               fl_req,
  input wire upd_pkg::flash_op_t fl_op,
  input wire logic [12:0]        fl_addr,
  input wire logic [15:0]        fl_wdata,
  input wire logic               fl_ack
);
  import upd_pkg::*;

  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  req_hold_a: assert property (fl_req && !fl_ack |=> fl_req && $stable(fl_addr)
    && $stable(fl_op) && $stable(fl_wdata))
    else $error("flash request changed before acknowledge");
  stall_req_a: assert property (fl_req |-> stall)
    else $error("flash busy without stall");
  no_access_a: assert property (stall |-> !wr && !rd)
    else $error("register access during stall");
  stall_cause_a: assert property ($rose(stall) |-> $past(wr) && $past(addr) == 4'h0)
    else $error("stall rose without a control write");
  erase_base_a: assert property (fl_req && fl_op == FL_ERASE |-> fl_addr[4:0] == 5'h00)
    else $error("erase not at page base");
  prog_start_a: assert property ($rose(fl_req) && fl_op == FL_PROG |-> fl_addr[4:0] == 5'h00)
    else $error("program not started at page base");
  prog_next_a: assert property (fl_ack && fl_req && fl_op == FL_PROG
    && fl_addr[4:0] != 5'h1F |=> fl_req && fl_op == FL_PROG && fl_addr == $past(fl_addr) + 13'h1)
    else $error("program word sequence broken");
  op_end_a: assert property (fl_ack && fl_req && (fl_op != FL_PROG
    || fl_addr[4:0] == 5'h1F) |=> !fl_req ##[0:1] !stall)
    else $error("operation did not end after last acknowledge");
  rdata_hold_a: assert property (!$past(rd) |-> $stable(rdata))
    else $error("read answer changed without a read");
endmodule
